// ===== inc/misc_ctrl_pkg.sv
// Package: register map, field positions and reset values of the group
package misc_ctrl_pkg;

    // Register offsets
    localparam logic [6:0] ADDR_SCRATCH   = 7'h41;
    localparam logic [6:0] ADDR_PHASE     = 7'h42;
    localparam logic [6:0] ADDR_PHASE_RB  = 7'h43;
    localparam logic [6:0] ADDR_TEST_WE   = 7'h49;
    localparam logic [6:0] ADDR_FILTER    = 7'h4a;
    localparam logic [6:0] ADDR_STATUS    = 7'h4b;
    localparam logic [6:0] ADDR_SOFT_RST  = 7'h5f;

    // Reset values
    localparam logic [7:0] RST_SCRATCH    = 8'h00;
    localparam logic [5:0] RST_PHASE      = 6'h20;
    localparam logic [7:0] RST_TEST_WE    = 8'h00;
    localparam logic [7:0] RST_FILTER     = 8'h14;
    localparam logic [7:0] RST_STATUS     = 8'h00;
    localparam logic [7:0] RST_SOFT_RST   = 8'h00;

    // Field positions
    localparam int POS_SCRATCH        = 0;
    localparam int POS_TEST_WE        = 7;
    localparam int POS_DRIVE_MODE     = 7;
    localparam int POS_FILT_ACC       = 1;
    localparam int POS_FILT_CLKG      = 0;
    localparam int POS_LOW_GAIN_STS   = 3;
    localparam int POS_GAIN_CTRL_STS  = 2;
    localparam int POS_SIG_STR_STS    = 1;

    // Test-only positions of the filter register, forced to reset value
    localparam logic [7:0] FILTER_TEST_MASK = 8'h7c;

    // Soft reset key and phase midpoint
    localparam logic [7:0] SOFT_RESET_KEY = 8'haa;
    localparam logic [5:0] PHASE_MID      = 6'h20;
    localparam logic [4:0] PHASE_MAX_STEP = 5'h1f;

    // Length of the internal soft reset pulse, in clock cycles
    localparam int SOFT_RESET_CYCLES = 4;

endpackage

// ===== inc/reg_link_if.sv
// Interface: register access link between host and register group
interface reg_link_if;
    logic       wr_en;
    logic       rd_en;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       rvalid;

    modport device (
        input  wr_en,
        input  rd_en,
        input  addr,
        input  wdata,
        output rdata,
        output rvalid
    );

    modport host (
        output wr_en,
        output rd_en,
        output addr,
        output wdata,
        input  rdata,
        input  rvalid
    );
endinterface

// ===== src/misc_ctrl_regs.sv
// Device end: misc control register group with phase, filter and status
//
// Function
// - Scratch bit read/write, affects nothing else.
// - Six-bit code maps to I or Q correction.
// - Phase readback returns written code unmodified.
// - Filter/status writes need test-write enable set.
// - Host writes test bits at default values.
// - Accumulator bit: zero pseudo-random, one homogenized.
// - Clock-gating bit: zero off, one on.
// - Status mask bits pass live status or zero.
// - Only key pattern triggers software reset.
// - Reset key register self-clears after reset.
module misc_ctrl_regs #(
    parameter int RESET_CYCLES = misc_ctrl_pkg::SOFT_RESET_CYCLES
) (
    // Clock, reset and enable
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    // Register link
    reg_link_if.device      link,
    // Live block status
    input  wire logic       low_gain_status_i,
    input  wire logic       gain_control_status_i,
    input  wire logic       signal_strength_status_i,
    // Status bits toward the converter serial stream
    output logic            low_gain_status_o,
    output logic            gain_control_status_o,
    output logic            signal_strength_status_o,
    // Filter controls
    output logic            filter_accumulator_method_o,
    output logic            filter_clock_gating_o,
    output logic            drive_boost_o,
    // Phase correction magnitudes, in 0.125 degree steps
    output logic [4:0]      phase_i_steps_o,
    output logic [4:0]      phase_q_steps_o,
    // Soft reset pulse to the rest of the chip
    output logic            soft_reset_o
);

    logic       scratch_r;
    logic [5:0] phase_r;
    logic [7:0] test_we_r;
    logic [7:0] filter_r;
    logic [7:0] status_r;
    logic [7:0] soft_key_r;
    logic [7:0] rdata_r;
    logic       rvalid_r;
    logic [2:0] sts_out_r;
    logic [7:0] rst_cnt_r;
    logic [7:0] rst_cnt_nxt;
    logic       resetting_r;

    // Write decode
    wire        wr = ce_i && link.wr_en;
    wire        wr_scratch = wr && (link.addr == misc_ctrl_pkg::ADDR_SCRATCH);
    wire        wr_phase   = wr && (link.addr == misc_ctrl_pkg::ADDR_PHASE);
    wire        wr_test_we = wr && (link.addr == misc_ctrl_pkg::ADDR_TEST_WE);
    wire        test_we_on = test_we_r[misc_ctrl_pkg::POS_TEST_WE];
    wire        wr_filter  = wr && test_we_on
                             && (link.addr == misc_ctrl_pkg::ADDR_FILTER);
    wire        wr_status  = wr && test_we_on
                             && (link.addr == misc_ctrl_pkg::ADDR_STATUS);
    wire        wr_key     = wr && (link.addr == misc_ctrl_pkg::ADDR_SOFT_RST);
    wire        key_hit    = wr_key
                             && (link.wdata == misc_ctrl_pkg::SOFT_RESET_KEY);
    wire        rst_done   = resetting_r && (rst_cnt_r == 8'h01);

    // Phase code to correction magnitude
    function automatic logic [4:0] i_steps(input logic [5:0] code);
        if (code[5])
            i_steps = 5'h00;
        else if (code[4:1] == 4'h0)
            i_steps = misc_ctrl_pkg::PHASE_MAX_STEP;
        else
            i_steps = 5'(misc_ctrl_pkg::PHASE_MID - code);
    endfunction

    // Read mux; unmapped addresses read as zero
    logic [7:0] rmux;
    always_comb
    begin
        case (link.addr)
            misc_ctrl_pkg::ADDR_SCRATCH:  rmux = {7'h00, scratch_r};
            misc_ctrl_pkg::ADDR_PHASE:    rmux = {2'h0, phase_r};
            misc_ctrl_pkg::ADDR_PHASE_RB: rmux = {2'h0, phase_r};
            misc_ctrl_pkg::ADDR_TEST_WE:  rmux = {test_we_r[7], 7'h00};
            misc_ctrl_pkg::ADDR_FILTER:   rmux = filter_r;
            misc_ctrl_pkg::ADDR_STATUS:   rmux = status_r;
            misc_ctrl_pkg::ADDR_SOFT_RST: rmux = soft_key_r;
            default:                      rmux = 8'h00;
        endcase
    end

    // Configuration registers; soft reset returns them to defaults
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            scratch_r <= misc_ctrl_pkg::RST_SCRATCH[0];
            phase_r   <= misc_ctrl_pkg::RST_PHASE;
            test_we_r <= misc_ctrl_pkg::RST_TEST_WE;
            filter_r  <= misc_ctrl_pkg::RST_FILTER;
            status_r  <= misc_ctrl_pkg::RST_STATUS;
        end
        else if (ce_i && rst_done)
        begin
            scratch_r <= misc_ctrl_pkg::RST_SCRATCH[0];
            phase_r   <= misc_ctrl_pkg::RST_PHASE;
            test_we_r <= misc_ctrl_pkg::RST_TEST_WE;
            filter_r  <= misc_ctrl_pkg::RST_FILTER;
            status_r  <= misc_ctrl_pkg::RST_STATUS;
        end
        else
        begin
            if (wr_scratch)
                scratch_r <= link.wdata[misc_ctrl_pkg::POS_SCRATCH];
            if (wr_phase)
                phase_r <= link.wdata[5:0];
            if (wr_test_we)
                test_we_r <= {link.wdata[misc_ctrl_pkg::POS_TEST_WE], 7'h00};
            if (wr_filter)
                filter_r <= link.wdata;
            if (wr_status)
                status_r <= link.wdata;
        end
    end

    // Soft reset sequencer; a new host write beats the self-clear
    assign rst_cnt_nxt = key_hit ? 8'(RESET_CYCLES)
                       : (resetting_r ? rst_cnt_r - 8'h01 : rst_cnt_r);
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            soft_key_r  <= misc_ctrl_pkg::RST_SOFT_RST;
            rst_cnt_r   <= 8'h00;
            resetting_r <= 1'b0;
        end
        else if (ce_i)
        begin
            rst_cnt_r   <= rst_cnt_nxt;
            resetting_r <= key_hit || (resetting_r && !rst_done);
            if (wr_key)
                soft_key_r <= link.wdata;
            else if (rst_done)
                soft_key_r <= misc_ctrl_pkg::RST_SOFT_RST;
        end
    end
    assign soft_reset_o = resetting_r;

    // Read answer one cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end
        else if (ce_i)
        begin
            rvalid_r <= link.rd_en;
            if (link.rd_en)
                rdata_r <= rmux;
        end
    end
    assign link.rdata  = rdata_r;
    assign link.rvalid = rvalid_r;

    // Masked status bits, registered to keep the stream glitch free
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            sts_out_r <= 3'h0;
        else if (ce_i)
            sts_out_r <= {
                low_gain_status_i
                    & status_r[misc_ctrl_pkg::POS_LOW_GAIN_STS],
                gain_control_status_i
                    & status_r[misc_ctrl_pkg::POS_GAIN_CTRL_STS],
                signal_strength_status_i
                    & status_r[misc_ctrl_pkg::POS_SIG_STR_STS]};
    end
    assign low_gain_status_o        = sts_out_r[2];
    assign gain_control_status_o    = sts_out_r[1];
    assign signal_strength_status_o = sts_out_r[0];

    // Filter controls straight from the register
    // accumulator select
    assign filter_accumulator_method_o =
        filter_r[misc_ctrl_pkg::POS_FILT_ACC];
    assign filter_clock_gating_o = filter_r[misc_ctrl_pkg::POS_FILT_CLKG];
    assign drive_boost_o         = filter_r[misc_ctrl_pkg::POS_DRIVE_MODE];

    assign phase_i_steps_o = i_steps(phase_r);
    assign phase_q_steps_o = phase_r[5] ? phase_r[4:0] : 5'h00;

endmodule // misc_ctrl_regs

// ===== src/misc_ctrl_host.sv
// Host end: turns user commands into register link accesses
module misc_ctrl_host (
    // Clock, reset and enable
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    // User command port
    input  wire logic       cmd_valid_i,
    input  wire logic       cmd_write_i,
    input  wire logic [6:0] cmd_addr_i,
    input  wire logic [7:0] cmd_wdata_i,
    output logic            cmd_ready_o,
    // User read answer
    output logic            rsp_valid_o,
    output logic [7:0]      rsp_data_o,
    // Register link
    reg_link_if.host        link
);

    typedef enum logic [1:0] {IDLE, WAIT_READ} host_state_e;

    host_state_e state_r;
    logic        wr_r;
    logic        rd_r;
    logic [6:0]  addr_r;
    logic [7:0]  wdata_r;
    logic        rsp_valid_r;
    logic [7:0]  rsp_data_r;

    wire take = ce_i && cmd_valid_i && (state_r == IDLE);
    // keep test bits at defaults; other bits from the user
    wire [7:0] safe_wdata =
        (cmd_addr_i == misc_ctrl_pkg::ADDR_FILTER)
        ? ((cmd_wdata_i & ~misc_ctrl_pkg::FILTER_TEST_MASK)
           | (misc_ctrl_pkg::RST_FILTER & misc_ctrl_pkg::FILTER_TEST_MASK))
        : cmd_wdata_i;

    assign cmd_ready_o = (state_r == IDLE);

    // One access at a time; reads wait for their answer
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_r     <= IDLE;
            wr_r        <= 1'b0;
            rd_r        <= 1'b0;
            addr_r      <= 7'h00;
            wdata_r     <= 8'h00;
            rsp_valid_r <= 1'b0;
            rsp_data_r  <= 8'h00;
        end
        else if (ce_i)
        begin
            wr_r        <= take && cmd_write_i;
            rd_r        <= take && !cmd_write_i;
            rsp_valid_r <= 1'b0;
            if (take)
            begin
                addr_r  <= cmd_addr_i;
                wdata_r <= safe_wdata;
            end
            case (state_r)
                IDLE:
                    if (take && !cmd_write_i)
                        state_r <= WAIT_READ;
                WAIT_READ:
                    if (link.rvalid)
                    begin
                        rsp_valid_r <= 1'b1;
                        rsp_data_r  <= link.rdata;
                        state_r     <= IDLE;
                    end
                default:
                    state_r <= IDLE;
            endcase
        end
    end

    assign link.wr_en = wr_r;
    assign link.rd_en = rd_r;
    assign link.addr  = addr_r;
    assign link.wdata = wdata_r;
    assign rsp_valid_o = rsp_valid_r;
    assign rsp_data_o  = rsp_data_r;

endmodule // misc_ctrl_host

// ===== testbench/misc_ctrl_assertions.sv
// Checker: link handshake and readback relations of the register group
module misc_ctrl_assertions (
    // Clock, reset and enable
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    // Register link
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    input  wire logic [6:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic [7:0] rdata,
    input  wire logic       rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Strobes count only with the enable high, as the device sees them
    wire logic wr_ok = wr_en && ce_i;
    wire logic rd_ok = rd_en && ce_i;
    wire logic mapped = addr inside {7'h41, 7'h42, 7'h43, 7'h49, 7'h4a,
                                     7'h4b, 7'h5f};

    read_answer_a: assert property (rd_ok |=> rvalid)
        else $error("read strobe got no answer");
    // A low enable freezes the answer, so only enabled edges are judged
    answer_cause_a: assert property (
        rvalid && $past(ce_i) |-> $past(rd_ok))
        else $error("answer without a read strobe");
    rvalid_pulse_a: assert property (rvalid && ce_i |=> !rvalid)
        else $error("answer longer than one cycle");
    scratch_echo_a: assert property (
        wr_ok && addr == 7'h41 ##1 rd_ok && addr == 7'h41
        |=> rdata == {7'h00, $past(wdata[0], 2)})
        else $error("scratch bit not read back");
    phase_echo_a: assert property (
        wr_ok && addr == 7'h42 ##1 rd_ok && addr == 7'h43
        |=> rdata == {2'h0, $past(wdata[5:0], 2)})
        else $error("phase readback differs from code");
    enable_echo_a: assert property (
        wr_ok && addr == 7'h49 ##1 rd_ok && addr == 7'h49
        |=> rdata == {$past(wdata[7], 2), 7'h00})
        else $error("write enable bit not read back");
    key_store_a: assert property (
        wr_ok && addr == 7'h5f ##1 rd_ok && addr == 7'h5f
        |=> rdata == $past(wdata, 2))
        else $error("reset key register not stored");
    unmapped_zero_a: assert property (
        rd_ok && !mapped |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    // Main scenarios reached
    key_write_c: cover property (wr_ok && addr == 7'h5f && wdata == 8'haa);
    filter_write_c: cover property (wr_ok && addr == 7'h4a);
    unmapped_read_c: cover property (rd_ok && !mapped);
endmodule // misc_ctrl_assertions

// ===== testbench/tb_top.sv
// Testbench: host end and register group joined over the link
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // Shortened soft reset pulse
    localparam int RCYC = 3;

    logic       clk_i       = 1'b0;
    logic       rst_n_i     = 1'b0;
    logic       ce_i        = 1'b1;
    logic       cmd_valid_i = 1'b0;
    logic       cmd_write_i = 1'b0;
    logic [6:0] cmd_addr_i  = 7'h00;
    logic [7:0] cmd_wdata_i = 8'h00;
    logic [2:0] sts         = 3'h0;
    logic       cmd_ready_o, rsp_valid_o, soft_reset_o;
    logic       low_gain_status_o, gain_control_status_o;
    logic       signal_strength_status_o, drive_boost_o;
    logic       filter_accumulator_method_o, filter_clock_gating_o;
    logic [7:0] rsp_data_o;
    logic [4:0] phase_i_steps_o, phase_q_steps_o;
    int         failures  = 0;
    int         cmp_count = 0;
    logic [7:0] pulses    = 8'h00;
    logic [6:0] amap [8] = '{7'h41, 7'h42, 7'h43, 7'h49, 7'h4a, 7'h4b,
                             7'h5f, 7'h50};
    logic [7:0] rmap [8] = '{8'h00, 8'h20, 8'h20, 8'h00, 8'h14, 8'h00,
                             8'h00, 8'h00};
    logic [5:0] codes [6] = '{6'h00, 6'h01, 6'h1f, 6'h20, 6'h21, 6'h3f};
    // Device outputs packed for one compare
    wire logic [7:0] outs = {drive_boost_o, filter_accumulator_method_o,
        filter_clock_gating_o, low_gain_status_o, gain_control_status_o,
        signal_strength_status_o, 2'h0};

    reg_link_if link ();
    misc_ctrl_host u_misc_ctrl_host (.clk_i, .rst_n_i, .ce_i, .cmd_valid_i,
        .cmd_write_i, .cmd_addr_i, .cmd_wdata_i, .cmd_ready_o, .rsp_valid_o,
        .rsp_data_o, .link(link));
    misc_ctrl_regs #(.RESET_CYCLES(RCYC)) u_misc_ctrl_regs (.clk_i,
        .rst_n_i, .ce_i, .link(link), .low_gain_status_i(sts[2]),
        .gain_control_status_i(sts[1]), .signal_strength_status_i(sts[0]),
        .low_gain_status_o, .gain_control_status_o,
        .signal_strength_status_o, .filter_accumulator_method_o,
        .filter_clock_gating_o, .drive_boost_o, .phase_i_steps_o,
        .phase_q_steps_o, .soft_reset_o);
    misc_ctrl_assertions u_misc_ctrl_assertions (.clk_i, .rst_n_i, .ce_i,
        .wr_en(link.wr_en), .rd_en(link.rd_en), .addr(link.addr),
        .wdata(link.wdata), .rdata(link.rdata), .rvalid(link.rvalid));

    // Clock and soft reset pulse length counter
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i)
        if (soft_reset_o === 1'b1)
            pulses <= pulses + 8'h01;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Command stays presented until taken, so writes run back to back
    task automatic cmd(input logic w, input logic [6:0] a,
                       input logic [7:0] d);
        cmd_valid_i <= 1'b1;
        cmd_write_i <= w;
        cmd_addr_i  <= a;
        cmd_wdata_i <= d;
        do @(posedge clk_i); while (cmd_ready_o !== 1'b1);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        cmd(1'b1, a, d);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        cmd(1'b0, a, 8'h00);
        cmd_valid_i <= 1'b0;
        do @(posedge clk_i); while (rsp_valid_o !== 1'b1);
        chk(rsp_data_o, exp);
    endtask

    task automatic idle(input int n);
        cmd_valid_i <= 1'b0;
        repeat (n) @(posedge clk_i);
    endtask

    // I steps: code zero ignores bit0 and shares the deepest step
    function automatic logic [7:0] isteps(input logic [5:0] c);
        if (c == 6'h00) return 8'h1f;
        return c[5] ? 8'h00 : 8'h20 - {2'h0, c};
    endfunction

    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog well beyond the expected fewer than two hundred cycles
    initial
    begin
        repeat (6000) @(posedge clk_i);
        failures++;
        $display("Error at %0t: timeout", $time);
        finish_test();
    end

    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        foreach (amap[k]) rd(amap[k], rmap[k]);
        chk(outs, 8'h00);
        wr(7'h41, 8'hff);
        rd(7'h41, 8'h01);
        chk(outs, 8'h00);
        chk({3'h0, phase_i_steps_o}, 8'h00);
        foreach (codes[k])
        begin
            wr(7'h42, {2'h3, codes[k]});
            rd(7'h43, {2'h0, codes[k]});
            chk({3'h0, phase_i_steps_o}, isteps(codes[k]));
            chk({3'h0, phase_q_steps_o}, codes[k][5] ?
                {3'h0, codes[k][4:0]} : 8'h00);
        end
        wr(7'h43, 8'h00);
        rd(7'h43, 8'h3f);
        wr(7'h4a, 8'h17);
        rd(7'h4a, 8'h14);
        wr(7'h4b, 8'h0e);
        rd(7'h4b, 8'h00);
        wr(7'h49, 8'hff);
        rd(7'h49, 8'h80);
        wr(7'h4a, 8'h83);
        rd(7'h4a, 8'h97);
        chk(outs, 8'he0);
        wr(7'h4a, 8'h02);
        idle(3);
        chk(outs, 8'h40);
        sts <= 3'h7;
        wr(7'h4b, 8'h0a);
        idle(3);
        chk(outs, 8'h54);
        wr(7'h4b, 8'h04);
        idle(3);
        chk(outs, 8'h48);
        sts <= 3'h5;
        idle(3);
        chk(outs, 8'h40);
        // Enable low must freeze the status stage against a live change
        ce_i <= 1'b0;
        sts  <= 3'h7;
        idle(3);
        chk(outs, 8'h40);
        ce_i <= 1'b1;
        idle(3);
        chk(outs, 8'h48);
        wr(7'h5f, 8'h55);
        rd(7'h5f, 8'h55);
        chk(pulses, 8'h00);
        wr(7'h5f, 8'haa);
        rd(7'h5f, 8'haa);
        idle(8);
        chk(pulses, RCYC[7:0]);
        rd(7'h5f, 8'h00);
        rd(7'h4a, 8'h14);
        rd(7'h42, 8'h20);
        idle(2);
        finish_test();
    end
endmodule // tb_top
